// >>> control_pin_function_mux_bench.sv
// Purpose: Self-checking bench for the control pin function mux
// Assumes: 10 MHz clock, LED hold shortened to 8 cycles
// Notes: Pin levels are expected one clock after their cause
`timescale 1ns/1ns
module control_pin_function_mux_bench;
	localparam int HOLD = 8;
	// Arbitrary identification value
	localparam logic [31:0] ID = 32'hC0DE_1234;
	logic clock, reset_n, por_n, avs_read, avs_write, avs_waitrequest;
	logic suspend, configured, uart_tx_active, host_out_xfer, host_in_xfer;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0] port_i, port_o, port_oe_n, ext_byte, b, e;
	logic [4:0] pin_i, pin_o, pin_oe_n, prev;
	int miscompares, samples_checked, cycles, wr_cnt, rd_cnt, w0, r0, base;
	int lows[5], togs[5], t0[5];
	cpfm_top #(.LED_HOLD(HOLD), .UNIT_ID(ID)) i_cpfm_top (.CLOCK(clock), .RESET_N(reset_n), .POR_N(por_n),
		.CLK_EN(1'h1), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .SUSPEND(suspend), .CONFIGURED(configured),
		.UART_TX_ACTIVE(uart_tx_active), .HOST_OUT_XFER(host_out_xfer), .HOST_IN_XFER(host_in_xfer),
		.UART_LINE_O(8'h00), .UART_LINE_OE_N(8'hFF), .PORT_I(port_i), .PORT_O(port_o),
		.PORT_OE_N(port_oe_n), .CTRL_PIN_I(pin_i), .CTRL_PIN_O(pin_o), .CTRL_PIN_OE_N(pin_oe_n));
	cpfm_ext_model i_cpfm_ext_model (.clk(clock), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .port_o(port_o),
		.port_oe_n(port_oe_n), .ext_byte(ext_byte), .pin_i(pin_i), .port_i(port_i), .wr_cnt(wr_cnt),
		.rd_cnt(rd_cnt));
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	// Low time and edge counts per pin
	always @(posedge clock) begin
		cycles++;
		for (int k = 0; k < 5; k++) begin
			lows[k] += (pin_o[k] === 1'h0);
			togs[k] += (pin_o[k] !== prev[k]);
		end
		prev = pin_o;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task chk(string name, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task bus(logic wr, logic [5:0] a, logic [31:0] d);
		@(posedge clock);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask : bus
	task rst;
		reset_n <= 1'h0;
		repeat (16) @(posedge clock);
		reset_n <= 1'h1;
		por_n <= 1'h1;
	endtask : rst
	// Pulse one or two transfers, then count low cycles
	task led(logic [1:0] w, int pin, int gap, int exp);
		base = lows[pin];
		{host_in_xfer, host_out_xfer} <= w;
		@(posedge clock) {host_in_xfer, host_out_xfer} <= 2'h0;
		if (gap > 0) begin
			repeat (gap) @(posedge clock);
			{host_in_xfer, host_out_xfer} <= w;
			@(posedge clock) {host_in_xfer, host_out_xfer} <= 2'h0;
		end
		repeat (HOLD + gap + 8) @(posedge clock);
		chk("led_low_cycles", exp, lows[pin] - base);
	endtask : led
	task clk_win(int cyc, logic on);
		#1 t0 = togs;
		repeat (cyc) @(posedge clock);
		#1;
		for (int k = 0; k < 4; k++)
			chk("clock_edges", on ? cyc >> k : 0, togs[k] - t0[k]);
	endtask : clk_win
	task close_out;
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial begin
		{reset_n, por_n, avs_read, avs_write, suspend, configured, uart_tx_active} = 7'h0;
		{host_out_xfer, host_in_xfer, avs_address, avs_writedata, ext_byte} = 48'h0;
		void'($urandom(32'hA103));
		rst();
		bus(1'h0, cpfm_pkg::A_ACTSEL, 32'h0);
		chk("actsel", cpfm_pkg::NV_DEFAULT, rd);
		bus(1'h1, cpfm_pkg::A_UNIT_ID, 32'hFFFF_FFFF);
		bus(1'h0, cpfm_pkg::A_UNIT_ID, 32'h0);
		chk("unit_id", ID, rd);
		bus(1'h0, 6'h3C, 32'h0);
		chk("unmapped", 32'h0, rd);
		repeat (64) begin
			@(posedge clock) {suspend, configured, uart_tx_active} <= 3'($urandom);
			@(posedge clock) #1;
			chk("pins", {!suspend, !(configured && !suspend), uart_tx_active}, pin_o[4:2]);
		end
		led(2'h1, 0, 0, HOLD);
		led(2'h2, 1, 3, HOLD + 4);
		$display("test defaults done");
		bus(1'h1, cpfm_pkg::A_NVCFG, {12'h0, cpfm_pkg::FN_GPIO, cpfm_pkg::FN_ANY_LED, cpfm_pkg::FN_GPIO,
			cpfm_pkg::FN_RDSTB, cpfm_pkg::FN_WRSTB});
		bus(1'h0, cpfm_pkg::A_ACTSEL, 32'h0);
		chk("actsel_held", cpfm_pkg::NV_DEFAULT, rd);
		rst();
		bus(1'h0, cpfm_pkg::A_ACTSEL, 32'h0);
		chk("actsel_new", 32'hA4ACB, rd);
		uart_tx_active <= 1'h1;
		bus(1'h1, cpfm_pkg::A_GPIO, 32'h40);
		bus(1'h0, cpfm_pkg::A_STATUS, 32'h0);
		chk("status_pins", 5'h1B, rd[4:0]);
		chk("pin4_released", 1'h1, pin_oe_n[4]);
		bus(1'h1, cpfm_pkg::A_PORT_DIR, 32'h0F);
		bus(1'h1, cpfm_pkg::A_CTRL, 32'h3);
		repeat (4) begin
			b = 8'($urandom);
			e = 8'($urandom);
			ext_byte <= e;
			w0 = wr_cnt;
			r0 = rd_cnt;
			bus(1'h1, cpfm_pkg::A_PORT_OUT, {24'h0, b});
			repeat (6) @(posedge clock);
			chk("wr_strobes", w0 + 1, wr_cnt);
			chk("rd_strobes", r0 + 1, rd_cnt);
			ext_byte <= ~e;
			bus(1'h0, cpfm_pkg::A_PORT_IN, 32'h0);
			chk("port_in", {e[7:4], b[3:0]}, rd[7:0]);
		end
		$display("test sync port done");
		bus(1'h1, cpfm_pkg::A_TIMER, 32'h3);
		bus(1'h1, cpfm_pkg::A_CTRL, 32'h1);
		w0 = wr_cnt;
		b = 8'($urandom);
		e = 8'($urandom);
		bus(1'h1, cpfm_pkg::A_PORT_OUT, {24'h0, e});
		bus(1'h1, cpfm_pkg::A_PORT_OUT, {24'h0, b});
		repeat (12) @(posedge clock);
		chk("async_strobes", w0 + 2, wr_cnt);
		chk("port_o", b[3:0], port_o[3:0]);
		ext_byte <= e;
		r0 = rd_cnt;
		bus(1'h0, cpfm_pkg::A_PORT_IN, 32'h0);
		chk("port_live", {e[7:4], b[3:0]}, rd[7:0]);
		repeat (3) @(posedge clock);
		chk("async_rd", r0 + 1, rd_cnt);
		$display("test async port done");
		bus(1'h1, cpfm_pkg::A_NVCFG, {12'h0, cpfm_pkg::FN_ANY_LED, cpfm_pkg::FN_CK6, cpfm_pkg::FN_CK12,
			cpfm_pkg::FN_CK24, cpfm_pkg::FN_CK48});
		suspend <= 1'h0;
		rst();
		led(2'h1, 4, 0, HOLD);
		led(2'h2, 4, 3, HOLD + 4);
		clk_win(32, 1'h1);
		suspend <= 1'h1;
		repeat (4) @(posedge clock);
		clk_win(16, 1'h0);
		suspend <= 1'h0;
		repeat (4) @(posedge clock);
		clk_win(16, 1'h1);
		$display("test clocks done");
		close_out();
	end
endmodule : control_pin_function_mux_bench

// >>> cpfm_ext_model.sv
// Purpose: Far side of the control pins and the parallel port
// Assumes: Every released control pin has a pull-up; released port lines read ext_byte
// Notes: External logic counts strobe cycles on pins 0 and 1
`timescale 1ns/1ns
module cpfm_ext_model (
	input logic clk,
	input logic [4:0] pin_o,
	input logic [4:0] pin_oe_n,
	input logic [7:0] port_o,
	input logic [7:0] port_oe_n,
	input logic [7:0] ext_byte,
	output logic [4:0] pin_i,
	output logic [7:0] port_i,
	output int wr_cnt,
	output int rd_cnt
);
	assign pin_i = pin_oe_n | pin_o;
	assign port_i = (port_oe_n & ext_byte) | (~port_oe_n & port_o);
	initial wr_cnt = 0;
	initial rd_cnt = 0;
	// Counts, on every clock, each cycle a strobe pin is driven low
	always @(posedge clk) begin
		wr_cnt += (pin_oe_n[0] === 1'h0 && pin_o[0] === 1'h0);
		rd_cnt += (pin_oe_n[1] === 1'h0 && pin_o[1] === 1'h0);
	end
endmodule : cpfm_ext_model

// >>> cpfm_pkg.sv
// Purpose: Shared constants and types for the control pin function mux
// Assumes: 10 MHz core clock, Avalon-MM register slave with byte addresses
// Notes: Register offsets are byte addresses of aligned 32-bit words
package cpfm_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NPINS = 5;
	localparam int SEL_W = 4;
	localparam int CFG_W = 20;
	localparam int PORT_W = 8;
	localparam int TMR_W = 14;
	localparam int LED_W = 18;
	localparam int CKD_W = 4;
	localparam int GPIO_PINS = 4;
	localparam int WRSTB_PINS = 2;
	localparam int RDSTB_PINS = 4;

	// ****************************************
	// Pin functions
	// ****************************************
	typedef enum logic [3:0] {
		FN_DRV_EN,
		FN_PWR_SW,
		FN_HOUT_LED,
		FN_HIN_LED,
		FN_ANY_LED,
		FN_SUSP,
		FN_CK48,
		FN_CK24,
		FN_CK12,
		FN_CK6,
		FN_GPIO,
		FN_WRSTB,
		FN_RDSTB
	} cpfm_fn_e;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [5:0] A_NVCFG = 6'h00;
	localparam logic [5:0] A_ACTSEL = 6'h04;
	localparam logic [5:0] A_CTRL = 6'h08;
	localparam logic [5:0] A_TIMER = 6'h0C;
	localparam logic [5:0] A_GPIO = 6'h10;
	localparam logic [5:0] A_STATUS = 6'h14;
	localparam logic [5:0] A_PORT_OUT = 6'h18;
	localparam logic [5:0] A_PORT_IN = 6'h1C;
	localparam logic [5:0] A_PORT_DIR = 6'h20;
	localparam logic [5:0] A_UNIT_ID = 6'h24;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CTRL_BB_ON = 0;
	localparam int CTRL_SYNC = 1;
	localparam int ST_SUSP = 5;
	localparam int ST_CONF = 6;
	localparam int ST_PEND = 7;
	localparam int GPIO_DIR_LSB = 4;
	localparam int PEND_BIT = 8;
	localparam logic [CFG_W-1:0] NV_DEFAULT = {FN_SUSP, FN_PWR_SW, FN_DRV_EN, FN_HIN_LED, FN_HOUT_LED};
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [TMR_W-1:0] TIMER_RST = 14'h0001;
	localparam logic [7:0] GPIO_RST = 8'h00;
	localparam logic [PORT_W-1:0] DIR_RST = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ = 10000;
	localparam int LED_HOLD_US = 20000;
	localparam int LED_HOLD_CYC = (LED_HOLD_US * CLK_KHZ + 999) / 1000;
endpackage : cpfm_pkg

// >>> cpfm_top.sv
// Purpose: Per-pin function selection for five control pins, bit-bang port
// Assumes: All inputs synchronous to CLOCK; POR_N only at power-up
// Notes: Clock outputs are scaled divisions of CLOCK in this model
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
module cpfm_top #(
	parameter int LED_HOLD = cpfm_pkg::LED_HOLD_CYC,
	// Arbitrary identification value
	parameter logic [31:0] UNIT_ID = 32'h5A5A_0001
) (
	input logic CLOCK,
	input logic RESET_N,
	input logic POR_N,
	input logic CLK_EN,
	input logic [5:0] AVS_ADDRESS,
	input logic AVS_READ,
	input logic AVS_WRITE,
	input logic [31:0] AVS_WRITEDATA,
	input logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input logic SUSPEND,
	input logic CONFIGURED,
	input logic UART_TX_ACTIVE,
	input logic HOST_OUT_XFER,
	input logic HOST_IN_XFER,
	input logic [7:0] UART_LINE_O,
	input logic [7:0] UART_LINE_OE_N,
	input logic [7:0] PORT_I,
	output logic [7:0] PORT_O,
	output logic [7:0] PORT_OE_N,
	input logic [4:0] CTRL_PIN_I,
	output logic [4:0] CTRL_PIN_O,
	output logic [4:0] CTRL_PIN_OE_N
);
	// ****************************************
	// State
	// ****************************************
	logic [cpfm_pkg::CFG_W-1:0] nv_q;
	logic [cpfm_pkg::CFG_W-1:0] nv_d;
	logic [cpfm_pkg::CFG_W-1:0] act_q;
	logic load_q;
	logic [1:0] ctrl_q;
	logic [1:0] ctrl_d;
	logic [cpfm_pkg::TMR_W-1:0] timer_q;
	logic [cpfm_pkg::TMR_W-1:0] timer_d;
	logic [cpfm_pkg::TMR_W-1:0] tmr_q;
	logic [7:0] gpio_q;
	logic [7:0] gpio_d;
	logic [7:0] dir_q;
	logic [7:0] dir_d;
	logic [7:0] port_o_q;
	logic [7:0] port_o_d;
	logic [7:0] pend_byte_q;
	logic pend_q;
	logic pend_d;
	logic [7:0] port_in_q;
	logic samp_q;
	logic samp_arm_q;
	logic wr_stb_q;
	logic rd_stb_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [cpfm_pkg::CKD_W-1:0] ckd_q;
	logic [cpfm_pkg::LED_W-1:0] led_cnt_q [2];

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
		hit = (a == o);
	endfunction : hit

	function automatic logic avail(input logic [3:0] f, input int k);
		case (f)
			cpfm_pkg::FN_GPIO: avail = (k < cpfm_pkg::GPIO_PINS);
			cpfm_pkg::FN_WRSTB: avail = (k < cpfm_pkg::WRSTB_PINS);
			cpfm_pkg::FN_RDSTB: avail = (k < cpfm_pkg::RDSTB_PINS);
			default: avail = (f <= cpfm_pkg::FN_RDSTB);
		endcase
	endfunction : avail

	// ****************************************
	// Bus decode
	// ****************************************
	wire logic req = AVS_READ | AVS_WRITE;
	wire logic bb_on = ctrl_q[cpfm_pkg::CTRL_BB_ON];
	wire logic sync_m = bb_on & ctrl_q[cpfm_pkg::CTRL_SYNC];
	wire logic async_m = bb_on & ~ctrl_q[cpfm_pkg::CTRL_SYNC];
	wire logic a_port_out = hit(AVS_ADDRESS, cpfm_pkg::A_PORT_OUT);
	wire logic a_port_in = hit(AVS_ADDRESS, cpfm_pkg::A_PORT_IN);
	// Async byte still waiting holds the next port write off
	wire logic port_busy = AVS_WRITE & a_port_out & async_m & pend_q;
	wire logic answer = wait_q & req & ~port_busy;
	wire logic wr_acc = AVS_WRITE & ~wait_q;
	wire logic rd_acc = AVS_READ & ~wait_q;
	wire logic wr_port = wr_acc & a_port_out;
	wire logic [31:0] bmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	wire logic [31:0] wmd = AVS_WRITEDATA & bmask;

	// ****************************************
	// Bit-bang timer
	// ****************************************
	wire logic tick = (tmr_q == '0);
	wire logic [cpfm_pkg::TMR_W-1:0] tmr_d = tick ? timer_q : tmr_q - 1'b1;
	wire logic async_out = async_m & tick & pend_q;

	// ****************************************
	// Register next values
	// ****************************************
	always_comb begin
		nv_d = nv_q;
		ctrl_d = ctrl_q;
		timer_d = timer_q;
		gpio_d = gpio_q;
		dir_d = dir_q;
		if (wr_acc) begin
			if (hit(AVS_ADDRESS, cpfm_pkg::A_NVCFG)) begin
				nv_d = (nv_q & ~bmask[cpfm_pkg::CFG_W-1:0]) | wmd[cpfm_pkg::CFG_W-1:0];
			end
			if (hit(AVS_ADDRESS, cpfm_pkg::A_CTRL) && AVS_BYTEENABLE[0]) begin
				ctrl_d = AVS_WRITEDATA[1:0];
			end
			if (hit(AVS_ADDRESS, cpfm_pkg::A_TIMER)) begin
				timer_d = (timer_q & ~bmask[cpfm_pkg::TMR_W-1:0]) | wmd[cpfm_pkg::TMR_W-1:0];
			end
			if (hit(AVS_ADDRESS, cpfm_pkg::A_GPIO) && AVS_BYTEENABLE[0]) begin
				gpio_d = AVS_WRITEDATA[7:0];
			end
			if (hit(AVS_ADDRESS, cpfm_pkg::A_PORT_DIR) && AVS_BYTEENABLE[0]) begin
				dir_d = AVS_WRITEDATA[7:0];
			end
		end
	end

	always_comb begin
		port_o_d = port_o_q;
		pend_d = pend_q;
		if (async_out) begin
			port_o_d = pend_byte_q;
			pend_d = 1'b0;
		end else if (wr_port && !async_m) begin
			port_o_d = AVS_WRITEDATA[7:0];
		end
		if (wr_port && async_m) begin
			pend_d = 1'b1;
		end
		if (!async_m) begin
			pend_d = 1'b0;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	wire logic [7:0] status = {pend_q, CONFIGURED, SUSPEND, CTRL_PIN_I};
	wire logic [7:0] port_rd = async_m ? PORT_I : port_in_q;
	wire logic [31:0] rd_mux =
		hit(AVS_ADDRESS, cpfm_pkg::A_NVCFG) ? {12'h000, nv_q} :
		hit(AVS_ADDRESS, cpfm_pkg::A_ACTSEL) ? {12'h000, act_q} :
		hit(AVS_ADDRESS, cpfm_pkg::A_CTRL) ? {30'h0000_0000, ctrl_q} :
		hit(AVS_ADDRESS, cpfm_pkg::A_TIMER) ? {18'h0_0000, timer_q} :
		hit(AVS_ADDRESS, cpfm_pkg::A_GPIO) ? {24'h00_0000, gpio_q} :
		hit(AVS_ADDRESS, cpfm_pkg::A_STATUS) ? {24'h00_0000, status} :
		a_port_out ? {23'h00_0000, pend_q, port_o_q} :
		a_port_in ? {24'h00_0000, port_rd} :
		hit(AVS_ADDRESS, cpfm_pkg::A_PORT_DIR) ? {24'h00_0000, dir_q} :
		hit(AVS_ADDRESS, cpfm_pkg::A_UNIT_ID) ? UNIT_ID :
		32'h0000_0000;

	// ****************************************
	// Activity indications
	// ****************************************
	wire logic [1:0] xfer = {HOST_IN_XFER, HOST_OUT_XFER};
	logic [1:0] led_on;
	for (genvar i = 0; i < 2; i++) begin : g_led
		assign led_on[i] = (led_cnt_q[i] != '0);
		always_ff @(posedge CLOCK or negedge RESET_N) begin
			if (!RESET_N) begin
				led_cnt_q[i] <= '0;
			end else if (CLK_EN) begin
				if (xfer[i]) begin
					led_cnt_q[i] <= cpfm_pkg::LED_W'(LED_HOLD);
				end else if (led_on[i]) begin
					led_cnt_q[i] <= led_cnt_q[i] - 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Per-pin function selection
	// ****************************************
	wire logic pwr_on = CONFIGURED & ~SUSPEND;
	logic [1:0] drv [cpfm_pkg::NPINS];

	function automatic logic [1:0] pin_drive(input logic [3:0] f, input int k);
		pin_drive = 2'h3;
		if (avail(f, k)) begin
			case (f)
				cpfm_pkg::FN_DRV_EN: pin_drive = {1'b0, UART_TX_ACTIVE};
				cpfm_pkg::FN_PWR_SW: pin_drive = {1'b0, ~pwr_on};
				cpfm_pkg::FN_HOUT_LED: pin_drive = {1'b0, ~led_on[0]};
				cpfm_pkg::FN_HIN_LED: pin_drive = {1'b0, ~led_on[1]};
				cpfm_pkg::FN_ANY_LED: pin_drive = {1'b0, ~(led_on[0] | led_on[1])};
				cpfm_pkg::FN_SUSP: pin_drive = {1'b0, ~SUSPEND};
				cpfm_pkg::FN_CK48: pin_drive = {1'b0, ckd_q[0]};
				cpfm_pkg::FN_CK24: pin_drive = {1'b0, ckd_q[1]};
				cpfm_pkg::FN_CK12: pin_drive = {1'b0, ckd_q[2]};
				cpfm_pkg::FN_CK6: pin_drive = {1'b0, ckd_q[3]};
				cpfm_pkg::FN_GPIO: pin_drive = {~gpio_q[cpfm_pkg::GPIO_DIR_LSB + k], gpio_q[k]};
				cpfm_pkg::FN_WRSTB: pin_drive = {1'b0, ~(bb_on & wr_stb_q)};
				cpfm_pkg::FN_RDSTB: pin_drive = {1'b0, ~(bb_on & rd_stb_q)};
				default: pin_drive = 2'h3;
			endcase
		end
	endfunction : pin_drive

	for (genvar k = 0; k < cpfm_pkg::NPINS; k++) begin : g_pin
		// One function per pin from its own field
		// Process form so levels read inside the function are tracked
		always_comb begin
			drv[k] = pin_drive(act_q[k*cpfm_pkg::SEL_W +: cpfm_pkg::SEL_W], k);
		end
		always_ff @(posedge CLOCK or negedge RESET_N) begin
			if (!RESET_N) begin
				CTRL_PIN_O[k] <= 1'b1;
				CTRL_PIN_OE_N[k] <= 1'b1;
			end else if (CLK_EN) begin
				CTRL_PIN_O[k] <= drv[k][0];
				CTRL_PIN_OE_N[k] <= drv[k][1];
			end
		end
	end

	// ****************************************
	// Configuration store
	// ****************************************
	// Survives RESET_N; only power-up restores the shipped selection
	always_ff @(posedge CLOCK or negedge POR_N) begin
		if (!POR_N) begin
			nv_q <= cpfm_pkg::NV_DEFAULT;
		end else if (CLK_EN) begin
			nv_q <= nv_d;
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			act_q <= cpfm_pkg::NV_DEFAULT;
			load_q <= 1'b1;
		end else if (CLK_EN && load_q) begin
			act_q <= nv_q;
			load_q <= 1'b0;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_q <= cpfm_pkg::CTRL_RST;
			timer_q <= cpfm_pkg::TIMER_RST;
			gpio_q <= cpfm_pkg::GPIO_RST;
			dir_q <= cpfm_pkg::DIR_RST;
		end else if (CLK_EN) begin
			ctrl_q <= ctrl_d;
			timer_q <= timer_d;
			gpio_q <= gpio_d;
			dir_q <= dir_d;
		end
	end

	// ****************************************
	// Bus handshake
	// ****************************************
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (CLK_EN) begin
			wait_q <= ~answer;
			if (answer && AVS_READ) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign AVS_WAITREQUEST = wait_q;
	assign AVS_READDATA = rdata_q;

	// ****************************************
	// Bit-bang port
	// ****************************************
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			tmr_q <= '0;
			port_o_q <= 8'h00;
			pend_byte_q <= 8'h00;
			pend_q <= 1'b0;
			port_in_q <= 8'h00;
			samp_q <= 1'b0;
			samp_arm_q <= 1'b0;
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
		end else if (CLK_EN) begin
			tmr_q <= tmr_d;
			port_o_q <= port_o_d;
			pend_q <= pend_d;
			if (wr_port && async_m) begin
				pend_byte_q <= AVS_WRITEDATA[7:0];
			end
			// Sample only once the new byte stands on the lines
			samp_arm_q <= sync_m & wr_port;
			samp_q <= samp_arm_q;
			if (samp_q) begin
				port_in_q <= PORT_I;
			end
			wr_stb_q <= async_out | (sync_m & wr_port);
			rd_stb_q <= samp_q | (async_m & rd_acc & a_port_in);
		end
	end

	// UART lines become the parallel port in bit-bang mode
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			PORT_O <= 8'hFF;
			PORT_OE_N <= 8'hFF;
		end else if (CLK_EN) begin
			PORT_O <= bb_on ? port_o_q : UART_LINE_O;
			PORT_OE_N <= bb_on ? ~dir_q : UART_LINE_OE_N;
		end
	end

	// ****************************************
	// Clock outputs
	// ****************************************
	// Divider frozen in suspend so all clock pins stop together
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ckd_q <= '0;
		end else if (CLK_EN && !SUSPEND) begin
			ckd_q <= ckd_q + 1'b1;
		end
	end
endmodule : cpfm_top

// >>> cpfm_top_props.sv
// Purpose: Pin function and bus timing checks for cpfm_top
// Assumes: Configuration writes use all byte lanes
// Notes: Mirrors the stored and active selections from bus traffic
`timescale 1ns/1ns
module cpfm_top_props (
	input logic CLOCK,
	input logic RESET_N,
	input logic POR_N,
	input logic [5:0] AVS_ADDRESS,
	input logic AVS_READ,
	input logic AVS_WRITE,
	input logic [31:0] AVS_WRITEDATA,
	input logic AVS_WAITREQUEST,
	input logic SUSPEND,
	input logic CONFIGURED,
	input logic UART_TX_ACTIVE,
	input logic HOST_OUT_XFER,
	input logic HOST_IN_XFER,
	input logic [4:0] CTRL_PIN_O,
	input logic [4:0] CTRL_PIN_OE_N
);
	logic [19:0] nv_q;
	logic [19:0] act_q;
	logic first_q;
	logic ok_q;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	always_ff @(posedge CLOCK or negedge POR_N) begin
		if (!POR_N)
			nv_q <= cpfm_pkg::NV_DEFAULT;
		else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == cpfm_pkg::A_NVCFG)
			nv_q <= AVS_WRITEDATA[19:0];
	end
	// Selection latched once after reset
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			first_q <= 1'h1;
			ok_q <= 1'h0;
			act_q <= 20'h0;
		end else begin
			first_q <= 1'h0;
			ok_q <= !first_q;
			if (first_q)
				act_q <= nv_q;
		end
	end
	for (genvar k = 0; k < 5; k++) begin : g_pin
		wire [3:0] f = act_q[4*k +: 4];
		wire led = (f == cpfm_pkg::FN_HOUT_LED && HOST_OUT_XFER) || (f == cpfm_pkg::FN_HIN_LED && HOST_IN_XFER)
			|| (f == cpfm_pkg::FN_ANY_LED && (HOST_OUT_XFER || HOST_IN_XFER));
		wire is_ck = f >= cpfm_pkg::FN_CK48 && f <= cpfm_pkg::FN_CK6;
		wire bad = f > 4'hC || (k == 4 && (f == cpfm_pkg::FN_GPIO || f == cpfm_pkg::FN_RDSTB))
			|| (k > 1 && f == cpfm_pkg::FN_WRSTB);
		a_drive_enable: assert property (ok_q && f == cpfm_pkg::FN_DRV_EN |=> CTRL_PIN_O[k] == $past(UART_TX_ACTIVE))
			else $error("drive enable pin wrong");
		a_power_switch: assert property (ok_q && f == cpfm_pkg::FN_PWR_SW
			|=> CTRL_PIN_O[k] == !($past(CONFIGURED) && !$past(SUSPEND))) else $error("power pin wrong");
		a_suspend_flag: assert property (ok_q && f == cpfm_pkg::FN_SUSP |=> CTRL_PIN_O[k] == !$past(SUSPEND))
			else $error("suspend pin wrong");
		a_led_hold: assert property (ok_q && led |-> ##2 !CTRL_PIN_O[k] [*7])
			else $error("led pulse too short");
		a_clock_runs: assert property ((ok_q && f == cpfm_pkg::FN_CK48 && !SUSPEND) [*3]
			|=> $changed(CTRL_PIN_O[k]) || SUSPEND) else $error("fast clock pin not toggling");
		a_clock_frozen: assert property ((ok_q && is_ck && SUSPEND) [*3] |=> $stable(CTRL_PIN_O[k]))
			else $error("clock pin toggles in suspend");
		a_refused_release: assert property (ok_q && bad |=> CTRL_PIN_OE_N[k])
			else $error("refused function drives pin");
	end
	a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_wait_bounded: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:40] !AVS_WAITREQUEST)
		else $error("request not answered");
endmodule : cpfm_top_props
bind cpfm_top cpfm_top_props i_props (.CLOCK, .RESET_N, .POR_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
	.AVS_WRITEDATA, .AVS_WAITREQUEST, .SUSPEND, .CONFIGURED, .UART_TX_ACTIVE, .HOST_OUT_XFER,
	.HOST_IN_XFER, .CTRL_PIN_O, .CTRL_PIN_OE_N);
